/* File: core/wdr_regs.svh */
// register offsets, fields, reset values and timing counts of the watchdog
`ifndef WDR_REGS_SVH
`define WDR_REGS_SVH
`define WDR_ADDR_W 4
`define WDR_OFS_CFG 4'h0
`define WDR_OFS_CTRL 4'h1
`define WDR_OFS_STAT 4'h2
`define WDR_OFS_MASK 4'h3
`define WDR_OFS_FLAGS 4'h4
// configuration word fields
`define WDR_CFG_POST_LO 0
`define WDR_CFG_PRE 4
`define WDR_CFG_ON 5
`define WDR_CFG_WINDOW_DISABLE_BIT 6
`define WDR_CFG_PWRT_LO 8
`define WDR_CFG_INITIAL_OSCILLATOR_SELECT_LO 12
`define WDR_CFG_POSC_LO 16
`define WDR_CFG_RESET 32'h0000_3040
// control / flags fields
`define WDR_CTRL_SWEN 0
`define WDR_FLG_BOR 1
`define WDR_FLG_IDLE 2
`define WDR_FLG_SLEEP 3
`define WDR_FLG_WATCHDOG_TIMEOUT_FLAG 4
`define WDR_FLG_SWEN 5
// interrupt status bits
`define WDR_EV_WATCHDOG_TIMEOUT_FLAG 0
`define WDR_EV_BOR 1
`define WDR_EV_WAKE 2
`define WDR_EV_W 3
// timing
`define WDR_CLK_MHZ 200
`define WDR_PRE_SHORT 32
`define WDR_PRE_LONG 128
`define WDR_SETTLE_US 20
`define WDR_SETTLE_CYC (`WDR_SETTLE_US * `WDR_CLK_MHZ)
`define WDR_PWRT_BASE_MS 2
`define WDR_FSCM_US 100
`define WDR_FSCM_CYC (`WDR_FSCM_US * `WDR_CLK_MHZ)
`define WDR_OST_CYC 1024
`endif

/* File: core/wdr_pkg.sv */
// types shared by the watchdog and brown-out reset block
package wdr_pkg;
    typedef enum logic [2:0] {
        WDR_ST_RESET = 3'b000,
        WDR_ST_SETTLE = 3'b001,
        WDR_ST_CLOCK = 3'b011,
        WDR_ST_PWRT = 3'b010,
        WDR_ST_RUN = 3'b110
    } wdr_state_t;
    typedef logic [31:0] wdr_word_t;
endpackage

/* File: core/wdr_watchdog.sv */
// watchdog timer with brown-out reset sequencing
// Notes on behaviour
// - watchdog counts low-power rc ticks; enabling watchdog enables that clock
// - prescaler divides rc clock by 32 or 128
// - four-bit postscaler field divides further, 1:1 up to 1:32768
// - count and scalers clear on reset, clock switch, sleep entry/exit, clear
// - enabled watchdog runs in sleep/idle; timeout wakes the core
// - timeout flag stays set until software clears it
// - always-on configuration bit forces watchdog on, software enable ignored
// - otherwise software enable starts or stops it; cleared on device reset
// - window mode: clear before last quarter of period causes reset
// - brown-out resets device, then picks clock from configuration fields
// - hold clock until start-up timer ends, and pll lock when used
// - apply power-up delay; zero delay with crystal uses fail-safe delay
// - brown-out reset sets the brown-out status bit
// - brown-out detection active in sleep and idle
// - after power-up or power-down resume, hold execution about 20 us
// - prescale bit one selects 1:128, zero selects 1:32
// - power-up field doubles 2 ms to 128 ms; code 000 disables
//
// Added by the designer: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "wdr_regs.svh"
module wdr_watchdog #(
    parameter int unsigned MS_CYC = 200000,
    parameter int unsigned SETTLE_CYC = `WDR_SETTLE_CYC,
    parameter int unsigned FSCM_CYC = `WDR_FSCM_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // register port
    input wire logic [`WDR_ADDR_W-1:0] reg_addr,
    input wire wdr_pkg::wdr_word_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output wdr_pkg::wdr_word_t reg_rdata,
    // core events
    input wire logic low_power_rc_clock,
    input wire logic watchdog_clear_instruction,
    input wire logic power_save_instruction,
    input wire logic power_save_idle,
    input wire logic clock_switch_done,
    input wire logic power_resume,
    // supply and clock status
    input wire logic brown_out_detect,
    input wire logic pll_lock,
    // outputs
    output logic low_power_rc_enable,
    output logic device_reset,
    output logic clock_hold,
    output logic exec_inhibit,
    output logic core_wake,
    output logic [2:0] selected_clock,
    output logic irq
);
    import wdr_pkg::*;

    // ==========================================================
    // registers
    wdr_word_t cfg_reg;
    logic swen_reg;
    logic [`WDR_EV_W-1:0] stat_reg;
    logic [`WDR_EV_W-1:0] mask_reg;
    logic watchdog_timeout_flag_reg;
    logic bor_flag_reg;
    logic sleep_reg;
    logic idle_reg;
    wdr_state_t state_reg;
    logic [31:0] delay_reg;
    logic [6:0] pre_reg;
    logic [15:0] post_reg;
    logic rc_q_reg;
    logic rc_tick;
    logic wdt_on;
    logic [15:0] post_limit;
    logic [6:0] pre_limit;
    logic timeout;
    logic early_clear;
    logic wdt_reset;
    logic scaler_clear;
    logic bor_event;
    logic in_reset;
    logic crystal;
    logic use_pll;
    logic [2:0] pwrt_code;
    logic [31:0] pwrt_cyc;

    function automatic logic hit(input logic [`WDR_ADDR_W-1:0] ofs);
        hit = (reg_addr == ofs);
    endfunction

    // ==========================================================
    // configuration decode
    assign pwrt_code = cfg_reg[`WDR_CFG_PWRT_LO +: 3];
    assign crystal = (cfg_reg[`WDR_CFG_POSC_LO +: 2] == 2'b01) ||
                     (cfg_reg[`WDR_CFG_POSC_LO +: 2] == 2'b10);
    assign use_pll = (cfg_reg[`WDR_CFG_INITIAL_OSCILLATOR_SELECT_LO +: 3] == 3'b001) ||
                     (cfg_reg[`WDR_CFG_INITIAL_OSCILLATOR_SELECT_LO +: 3] == 3'b011);
    // delay doubles from 2 ms; code zero gives none
    assign pwrt_cyc = (pwrt_code == 3'b000) ? 32'h0 :
        32'((`WDR_PWRT_BASE_MS * MS_CYC) << (pwrt_code - 3'd1));
    assign wdt_on = cfg_reg[`WDR_CFG_ON] | swen_reg;
    assign low_power_rc_enable = wdt_on;
    assign pre_limit = cfg_reg[`WDR_CFG_PRE] ?
        7'(`WDR_PRE_LONG - 1) : 7'(`WDR_PRE_SHORT - 1);
    assign post_limit = 16'((32'h1 << cfg_reg[`WDR_CFG_POST_LO +: 4]) - 1);
    assign selected_clock = cfg_reg[`WDR_CFG_INITIAL_OSCILLATOR_SELECT_LO +: 3];

    // ==========================================================
    // watchdog counting
    assign rc_tick = low_power_rc_clock & ~rc_q_reg;
    assign in_reset = (state_reg != WDR_ST_RUN);
    assign timeout = wdt_on && !in_reset && rc_tick &&
                     pre_reg == pre_limit && post_reg == post_limit;
    // clear before the last quarter of the postscaled period
    assign early_clear = watchdog_clear_instruction && wdt_on &&
        !cfg_reg[`WDR_CFG_WINDOW_DISABLE_BIT] && !sleep_reg && !idle_reg &&
        ({2'b00, post_reg} < ({2'b00, post_limit} + 18'd1) * 18'd3 / 18'd4);
    assign wdt_reset = (timeout && !sleep_reg && !idle_reg) || early_clear;
    assign scaler_clear = in_reset || clock_switch_done ||
        power_save_instruction || core_wake || watchdog_clear_instruction;
    assign core_wake = timeout && (sleep_reg || idle_reg);
    assign bor_event = brown_out_detect;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rc_q_reg <= 1'b0;
        end else if (clk_en) begin
            rc_q_reg <= low_power_rc_clock;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pre_reg <= 7'h00;
            post_reg <= 16'h0000;
        end else if (clk_en) begin
            if (scaler_clear || !wdt_on) begin
                pre_reg <= 7'h00;
                post_reg <= 16'h0000;
            end else if (rc_tick) begin
                if (pre_reg == pre_limit) begin
                    pre_reg <= 7'h00;
                    post_reg <= (post_reg == post_limit) ? 16'h0000 :
                        post_reg + 16'h0001;
                end else begin
                    pre_reg <= pre_reg + 7'h01;
                end
            end
        end
    end

    // ==========================================================
    // reset sequencer
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= WDR_ST_RESET;
            delay_reg <= 32'h0;
        end else if (clk_en) begin
            if (bor_event || wdt_reset) begin
                state_reg <= WDR_ST_RESET;
                delay_reg <= 32'h0;
            end else if (power_resume && state_reg == WDR_ST_RUN) begin
                state_reg <= WDR_ST_SETTLE;
                delay_reg <= 32'h0;
            end else begin
                case (state_reg)
                    WDR_ST_RESET: begin
                        state_reg <= WDR_ST_SETTLE;
                        delay_reg <= 32'h0;
                    end
                    WDR_ST_SETTLE: begin
                        if (delay_reg >= SETTLE_CYC - 1) begin
                            state_reg <= WDR_ST_CLOCK;
                            delay_reg <= 32'h0;
                        end else begin
                            delay_reg <= delay_reg + 32'h1;
                        end
                    end
                    WDR_ST_CLOCK: begin
                        if ((!crystal || delay_reg >= `WDR_OST_CYC - 1) &&
                            (!use_pll || pll_lock)) begin
                            state_reg <= WDR_ST_PWRT;
                            delay_reg <= 32'h0;
                        end else begin
                            delay_reg <= delay_reg + 32'h1;
                        end
                    end
                    WDR_ST_PWRT: begin
                        if ((pwrt_cyc != 32'h0 && delay_reg + 32'h1 >= pwrt_cyc)
                            || (pwrt_cyc == 32'h0 && (!crystal ||
                            delay_reg >= FSCM_CYC - 1))) begin
                            state_reg <= WDR_ST_RUN;
                        end else begin
                            delay_reg <= delay_reg + 32'h1;
                        end
                    end
                    WDR_ST_RUN: begin
                        state_reg <= WDR_ST_RUN;
                    end
                    default: begin
                        state_reg <= WDR_ST_RESET;
                    end
                endcase
            end
        end
    end

    assign device_reset = (state_reg == WDR_ST_RESET) ||
                          (state_reg == WDR_ST_PWRT) ||
                          (state_reg == WDR_ST_CLOCK) ||
                          (state_reg == WDR_ST_SETTLE);
    assign clock_hold = (state_reg == WDR_ST_CLOCK) ||
                        (state_reg == WDR_ST_SETTLE) ||
                        (state_reg == WDR_ST_RESET);
    assign exec_inhibit = in_reset;

    // ==========================================================
    // configuration and control
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg_reg <= `WDR_CFG_RESET;
        end else if (clk_en && reg_wr && hit(`WDR_OFS_CFG)) begin
            cfg_reg <= reg_wdata;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            swen_reg <= 1'b0;
        end else if (clk_en) begin
            if (state_reg == WDR_ST_RESET) begin
                swen_reg <= 1'b0;
            end else if (reg_wr && hit(`WDR_OFS_CTRL)) begin
                swen_reg <= reg_wdata[`WDR_CTRL_SWEN];
            end
        end
    end

    // ==========================================================
    // status flags: set wins over software clear
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            watchdog_timeout_flag_reg <= 1'b0;
            bor_flag_reg <= 1'b0;
        end else if (clk_en) begin
            if (timeout) begin
                watchdog_timeout_flag_reg <= 1'b1;
            end else if (reg_wr && hit(`WDR_OFS_FLAGS) &&
                         reg_wdata[`WDR_FLG_WATCHDOG_TIMEOUT_FLAG]) begin
                watchdog_timeout_flag_reg <= 1'b0;
            end
            if (bor_event) begin
                bor_flag_reg <= 1'b1;
            end else if (reg_wr && hit(`WDR_OFS_FLAGS) &&
                         reg_wdata[`WDR_FLG_BOR]) begin
                bor_flag_reg <= 1'b0;
            end
        end
    end

    // sleep and idle stay set after wake; software clears them
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sleep_reg <= 1'b0;
            idle_reg <= 1'b0;
        end else if (clk_en) begin
            if (power_save_instruction && !in_reset) begin
                sleep_reg <= !power_save_idle;
                idle_reg <= power_save_idle;
            end else if (reg_wr && hit(`WDR_OFS_FLAGS)) begin
                if (reg_wdata[`WDR_FLG_SLEEP]) begin
                    sleep_reg <= 1'b0;
                end
                if (reg_wdata[`WDR_FLG_IDLE]) begin
                    idle_reg <= 1'b0;
                end
            end
        end
    end

    // ==========================================================
    // interrupt status and mask
    logic [`WDR_EV_W-1:0] ev;
    assign ev = {core_wake, bor_event, timeout};

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mask_reg <= '0;
        end else if (clk_en) begin
            if (reg_wr && hit(`WDR_OFS_MASK)) begin
                mask_reg <= reg_wdata[`WDR_EV_W-1:0];
            end
        end
    end

    // one sticky bit per event; set wins over write-one-to-clear
    genvar gi;
    generate
        for (gi = 0; gi < `WDR_EV_W; gi++) begin : g_stat
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    stat_reg[gi] <= 1'b0;
                end else if (clk_en) begin
                    if (ev[gi]) begin
                        stat_reg[gi] <= 1'b1;
                    end else if (reg_wr && hit(`WDR_OFS_STAT) &&
                                 reg_wdata[gi]) begin
                        stat_reg[gi] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    assign irq = |(stat_reg & mask_reg);

    // ==========================================================
    // read port
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 32'h0;
        end else if (clk_en) begin
            if (reg_rd) begin
                case (reg_addr)
                    `WDR_OFS_CFG: reg_rdata <= cfg_reg;
                    `WDR_OFS_CTRL: reg_rdata <= {31'h0, swen_reg};
                    `WDR_OFS_STAT: reg_rdata <= {29'h0, stat_reg};
                    `WDR_OFS_MASK: reg_rdata <= {29'h0, mask_reg};
                    `WDR_OFS_FLAGS: reg_rdata <= {26'h0, wdt_on, watchdog_timeout_flag_reg,
                        sleep_reg, idle_reg, bor_flag_reg, 1'b0};
                    default: reg_rdata <= 32'h0;
                endcase
            end else begin
                reg_rdata <= 32'h0;
            end
        end
    end
endmodule

/* File: tb/wdr_watchdog_properties.sv */
// port assertions for the watchdog and brown-out reset block
`timescale 1ns/1ps
module wdr_watchdog_properties (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // register port
    input wire logic [3:0] reg_addr,
    input wire wdr_pkg::wdr_word_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire wdr_pkg::wdr_word_t reg_rdata,
    // events and outputs
    input wire logic brown_out_detect,
    input wire logic low_power_rc_enable,
    input wire logic device_reset,
    input wire logic clock_hold,
    input wire logic exec_inhibit,
    input wire logic core_wake,
    input wire logic [2:0] selected_clock,
    input wire logic irq
);
    import wdr_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // ==========================================
    // register side
    a_read_idle: assert property (clk_en && !reg_rd |=> reg_rdata == '0)
        else $error("read data not zero outside a read");
    a_clock_select: assert property (
        clk_en && reg_wr && reg_addr == 4'h0
        |=> selected_clock == $past(reg_wdata[14:12]))
        else $error("clock select does not follow config");
    a_always_on: assert property (
        clk_en && reg_wr && reg_addr == 4'h0 && reg_wdata[5]
        |=> low_power_rc_enable)
        else $error("rc clock off with always-on set");
    a_irq_quiet: assert property (
        clk_en && reg_wr && reg_addr == 4'h3 && reg_wdata == '0 |=> !irq)
        else $error("irq high with mask cleared");
    // ==========================================
    // reset sequencing
    a_brownout_reset: assert property (
        clk_en && brown_out_detect |=> device_reset)
        else $error("no reset during brown-out");
    a_settle_hold: assert property (
        $rose(device_reset) |-> device_reset [*4])
        else $error("reset shorter than settle time");
    a_exec_inhibit: assert property (exec_inhibit == device_reset)
        else $error("inhibit differs from reset");
    a_hold_in_reset: assert property (clock_hold |-> device_reset)
        else $error("clock held outside reset");
    a_hold_release: assert property ($fell(clock_hold) |-> device_reset)
        else $error("no power-up stage after clock hold");
    // ==========================================
    // wake-up
    a_wake_pulse: assert property (clk_en && core_wake |=> !core_wake)
        else $error("wake longer than one cycle");
    a_wake_no_reset: assert property (core_wake |-> !device_reset)
        else $error("reset during wake");
endmodule

bind wdr_watchdog wdr_watchdog_properties u_props (
    .clk(clk), .reset_n(reset_n), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .brown_out_detect(brown_out_detect),
    .low_power_rc_enable(low_power_rc_enable), .device_reset(device_reset),
    .clock_hold(clock_hold), .exec_inhibit(exec_inhibit),
    .core_wake(core_wake), .selected_clock(selected_clock), .irq(irq)
);

/* File: tb/wdr_watchdog_tb.sv */
// self-checking bench for the watchdog and brown-out reset block
`timescale 1ns/1ps
module wdr_watchdog_tb;
    import wdr_pkg::*;
    logic clk, reset_n, rc, bo, pll, idle, reg_wr, reg_rd;
    logic [3:0] ev, reg_addr;
    wdr_word_t reg_wdata, reg_rdata;
    logic rc_en, device_reset, clock_hold, exec_inhibit, core_wake, irq;
    logic [2:0] sel_clk;
    int num_errors, checked, cycles, wakes;
    wdr_word_t cfgs[3] = '{32'h60, 32'h61, 32'h70};
    int lens[3] = '{32, 64, 128};
    // ==========================================
    // clock, timeout and wake counter
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (core_wake === 1'b1) begin
            wakes++;
        end
        if (cycles == 20000) begin
            num_errors++;
            end_of_test;
        end
    end
    wdr_watchdog #(.MS_CYC(10), .SETTLE_CYC(4), .FSCM_CYC(8)) DUT (
        .clk(clk), .reset_n(reset_n), .clk_en(1'b1),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .low_power_rc_clock(rc), .watchdog_clear_instruction(ev[0]),
        .power_save_instruction(ev[1]), .power_save_idle(idle),
        .clock_switch_done(ev[2]), .power_resume(ev[3]),
        .brown_out_detect(bo), .pll_lock(pll),
        .low_power_rc_enable(rc_en), .device_reset(device_reset),
        .clock_hold(clock_hold), .exec_inhibit(exec_inhibit),
        .core_wake(core_wake), .selected_clock(sel_clk), .irq(irq)
    );
    // ==========================================
    // shared tasks
    task automatic chk(input wdr_word_t got, input wdr_word_t exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input wdr_word_t d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(negedge clk);
    endtask
    task automatic rd(input logic [3:0] a, input wdr_word_t m,
                      input wdr_word_t e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        chk(reg_rdata & m, e);
    endtask
    task automatic pulse(input int i);
        @(posedge clk);
        ev[i] <= 1'b1;
        @(posedge clk);
        ev[i] <= 1'b0;
    endtask
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge clk);
            rc <= 1'b1;
            repeat (2) @(posedge clk);
            rc <= 1'b0;
            @(posedge clk);
        end
        @(negedge clk);
    endtask
    task automatic wait_rst(input logic v, input int max);
        int i;
        i = 0;
        while (device_reset !== v && i < max) begin
            @(negedge clk);
            i++;
        end
        chk(32'(device_reset), 32'(v));
    endtask
    task automatic bo_pulse;
        @(posedge clk);
        bo <= 1'b1;
        repeat (3) @(posedge clk);
        bo <= 1'b0;
        @(negedge clk);
    endtask
    // ==========================================
    // scenarios
    task automatic t_reset;
        rd(4'h0, '1, 32'h3040);
        wr(4'hf, '1);
        rd(4'hf, '1, 32'h0);
        rd(4'h3, '1, 32'h0);
        wait_rst(1'b0, 100);
        chk(32'(sel_clk), 32'h3);
        chk(32'(irq), 32'h0);
    endtask
    task automatic t_swen;
        chk(32'(rc_en), 32'h0);
        wr(4'h1, 32'h1);
        chk(32'(rc_en), 32'h1);
        rd(4'h4, 32'h20, 32'h20);
        wr(4'h1, 32'h0);
        chk(32'(rc_en), 32'h0);
        wr(4'h0, 32'h3060);
        chk(32'(rc_en), 32'h1);
        wr(4'h0, 32'h3040);
        wr(4'h1, 32'h1);
        bo_pulse;
        wait_rst(1'b0, 3000);
        chk(32'(rc_en), 32'h0);
    endtask
    task automatic t_timeout;
        for (int k = 0; k < 3; k++) begin
            wr(4'h0, cfgs[k]);
            pulse(0);
            ticks(lens[k] - 1);
            chk(32'(device_reset), 32'h0);
            ticks(1);
            wait_rst(1'b1, 8);
            wait_rst(1'b0, 3000);
            rd(4'h4, 32'h10, 32'h10);
            rd(4'h4, 32'h10, 32'h10);
            wr(4'h4, 32'h10);
            rd(4'h4, 32'h10, 32'h0);
            rd(4'h2, 32'h1, 32'h1);
            wr(4'h2, 32'h1);
        end
    endtask
    task automatic t_switch;
        wr(4'h0, 32'h60);
        pulse(0);
        ticks(20);
        pulse(2);
        ticks(31);
        chk(32'(device_reset), 32'h0);
        ticks(1);
        wait_rst(1'b1, 8);
        wait_rst(1'b0, 3000);
        wr(4'h4, 32'h1e);
    endtask
    task automatic t_sleep;
        wr(4'h2, 32'h7);
        wr(4'h3, 32'h4);
        idle <= 1'b0;
        pulse(1);
        rd(4'h4, 32'h8, 32'h8);
        wakes = 0;
        ticks(32);
        chk(32'(wakes), 32'h1);
        chk(32'(device_reset), 32'h0);
        chk(32'(irq), 32'h1);
        rd(4'h4, 32'h8, 32'h8);
        wr(4'h4, 32'h8);
        rd(4'h4, 32'h8, 32'h0);
        wr(4'h2, 32'h4);
        chk(32'(irq), 32'h0);
        wr(4'h3, 32'h0);
        idle <= 1'b1;
        pulse(1);
        rd(4'h4, 32'h4, 32'h4);
        wr(4'h4, 32'h4);
    endtask
    task automatic t_window;
        wr(4'h0, 32'h62);
        pulse(0);
        wr(4'h0, 32'h22);
        ticks(100);
        pulse(0);
        repeat (6) @(negedge clk);
        chk(32'(device_reset), 32'h0);
        pulse(0);
        wait_rst(1'b1, 8);
        wait_rst(1'b0, 3000);
        wr(4'h4, 32'h1e);
    endtask
    task automatic t_brown;
        wr(4'h0, 32'h12040);
        pulse(1);
        bo_pulse;
        chk(32'(device_reset), 32'h1);
        chk(32'(sel_clk), 32'h2);
        repeat (900) @(negedge clk);
        chk(32'(clock_hold), 32'h1);
        wait_rst(1'b0, 400);
        rd(4'h4, 32'h2, 32'h2);
        wr(4'h4, 32'h1e);
        rd(4'h4, 32'h2, 32'h0);
        wr(4'h0, 32'h1040);
        pll <= 1'b0;
        bo_pulse;
        repeat (40) @(negedge clk);
        chk(32'(clock_hold), 32'h1);
        pll <= 1'b1;
        wait_rst(1'b0, 100);
        pulse(3);
        repeat (2) @(negedge clk);
        chk(32'(exec_inhibit), 32'h1);
        wait_rst(1'b0, 100);
    endtask
    task automatic end_of_test;
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ==========================================
    // main sequence
    initial begin
        clk = 1'b0;
        reset_n = 1'b0;
        {rc, bo, idle, reg_wr, reg_rd} = '0;
        pll = 1'b1;
        ev = '0;
        reg_addr = '0;
        reg_wdata = '0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        t_reset;
        t_swen;
        t_timeout;
        t_switch;
        t_sleep;
        t_window;
        t_brown;
        end_of_test;
    end
endmodule
